// ==== src/eight_bit_arith_logic_unit.sv ====
// Summary of operation
// - subtract source from destination, one cycle
// - add source plus carry, one cycle
// - word add immediate, two cycles, ZCNVS
// - word subtract immediate, two cycles, ZCNVS
// - subtract constant from destination, one cycle
// - subtract source and borrow, one cycle
// - subtract constant and borrow, one cycle
// - AND registers, flags Z N V
// - AND with constant, flags Z N V
// - OR registers, flags Z N V
// - OR with constant, flags Z N V
// - exclusive or registers, flags Z N V
// - set bits by constant mask
// - clear bits by inverted constant mask
// - test register against itself
`timescale 1ns/100ps
`default_nettype none

module eight_bit_arith_logic_unit
    import alu_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic opValid,
    input wire alu_pkg::alu_op_t opCode,
    input wire logic [7:0] destVal,
    input wire logic [7:0] srcVal,
    input wire logic [7:0] immVal,
    input wire logic [7:0] destHighVal,
    input wire logic [5:0] immWord,
    output logic busy,
    output logic resultValid,
    output logic resultWide,
    output logic productPair,
    output logic [7:0] resultLow,
    output logic [7:0] resultHigh,
    output logic [6:0] statusFlags
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // operation sequencer, idle unless a two-cycle op runs
    alu_state_t state_reg;
    alu_state_t state_next;

    // flag vector, bit order as in the package
    logic [5:0] flags_reg;
    logic [5:0] flags_next;

    // result bytes, held until the next result
    logic [7:0] low_reg;
    logic [7:0] low_next;
    logic [7:0] high_reg;
    logic [7:0] high_next;

    // one-cycle qualifiers that travel with a result
    logic valid_reg;
    logic valid_next;
    logic wide_reg;
    logic wide_next;
    logic pair_reg;
    logic pair_next;

    // word op sum with carry or borrow in the top bit
    logic [16:0] word_reg;
    logic [16:0] word_next;

    // word op direction and original pair, for overflow
    logic wordSub_reg;
    logic wordSub_next;
    logic [15:0] wordOrig_reg;
    logic [15:0] wordOrig_next;

    // ------------------------------------------------------------
    // datapath units
    // ------------------------------------------------------------
    // byte unit operand and outputs
    logic [7:0] byteOperand;
    logic [7:0] byteResult;
    logic [5:0] byteFlags;
    logic [5:0] byteTouched;

    // multiplier hookup
    logic [15:0] product;
    logic prodStart;

    // operand class of the request
    logic isImmOp;

    // ------------------------------------------------------------
    // operand select
    // ------------------------------------------------------------
    // immediate forms take the instruction constant as the operand
    always_comb
    begin
        case (opCode)
            OP_SUB_IMM, OP_SUB_IMM_BORROW, OP_AND_IMM, OP_OR_IMM,
            OP_SET_BITS, OP_CLEAR_BITS: isImmOp = 1'b1;
            default: isImmOp = 1'b0;
        endcase
        if (opCode == OP_TEST)
            byteOperand = destVal;
        else if (isImmOp)
            byteOperand = immVal;
        else
            byteOperand = srcVal;
    end

    // ------------------------------------------------------------
    // byte arithmetic and logic
    // ------------------------------------------------------------
    // carry in comes from the flag register, not from a port
    byte_logic_unit byteUnit (
        .op(opCode),
        .destVal(destVal),
        .srcVal(byteOperand),
        .carryIn(flags_reg[FLAG_C]),
        .result(byteResult),
        .flagsOut(byteFlags),
        .flagsTouched(byteTouched)
    );

    // ------------------------------------------------------------
    // multiplier
    // ------------------------------------------------------------
    // product is captured on the taking edge, read in the second cycle
    assign prodStart = opValid && (state_reg == ST_IDLE) &&
        (opCode == OP_PROD_UU || opCode == OP_PROD_SS || opCode == OP_PROD_SU);

    // signedness follows the op code: both, destination only, or none
    product_unit prodUnit (
        .mclk(mclk),
        .rst(rst),
        .start(prodStart),
        .aSigned(opCode != OP_PROD_UU),
        .bSigned(opCode == OP_PROD_SS),
        .aVal(destVal),
        .bVal(srcVal),
        .product(product)
    );

    // ------------------------------------------------------------
    // sequencer and result registers
    // ------------------------------------------------------------
    always_comb
    begin
        logic [15:0] wordRes;
        state_next = state_reg;
        flags_next = flags_reg;
        low_next = low_reg;
        high_next = high_reg;
        valid_next = 1'b0;
        wide_next = 1'b0;
        pair_next = 1'b0;
        word_next = word_reg;
        wordSub_next = wordSub_reg;
        wordOrig_next = wordOrig_reg;
        wordRes = word_reg[15:0];
        case (state_reg)
            ST_IDLE:
            begin
                if (opValid)
                begin
                    case (opCode)
                        OP_WORD_ADD, OP_WORD_SUB:
                        begin
                            // first cycle forms the 16-bit sum
                            wordOrig_next = {destHighVal, destVal};
                            wordSub_next = (opCode == OP_WORD_SUB);
                            if (opCode == OP_WORD_SUB)
                                word_next = {1'b0, destHighVal, destVal} - {11'h000, immWord};
                            else
                                word_next = {1'b0, destHighVal, destVal} + {11'h000, immWord};
                            state_next = ST_WORD;
                        end
                        OP_PROD_UU, OP_PROD_SS, OP_PROD_SU:
                            state_next = ST_PROD;
                        default:
                        begin
                            // single-cycle byte operation
                            low_next = byteResult;
                            valid_next = 1'b1;
                            flags_next = (flags_reg & ~byteTouched) | (byteFlags & byteTouched);
                        end
                    endcase
                end
            end
            ST_WORD:
            begin
                // second cycle writes the pair and flags
                low_next = wordRes[7:0];
                high_next = wordRes[15:8];
                valid_next = 1'b1;
                wide_next = 1'b1;
                flags_next[FLAG_Z] = (wordRes == 16'h0000);
                flags_next[FLAG_N] = wordRes[15];
                flags_next[FLAG_C] = word_reg[16];
                if (wordSub_reg)
                    flags_next[FLAG_V] = wordOrig_reg[15] & ~wordRes[15];
                else
                    flags_next[FLAG_V] = ~wordOrig_reg[15] & wordRes[15];
                flags_next[FLAG_S] = flags_next[FLAG_N] ^ flags_next[FLAG_V];
                state_next = ST_IDLE;
            end
            ST_PROD:
            begin
                // product lands in the fixed low register pair
                low_next = product[7:0];
                high_next = product[15:8];
                valid_next = 1'b1;
                wide_next = 1'b1;
                pair_next = 1'b1;
                flags_next[FLAG_Z] = (product == 16'h0000);
                flags_next[FLAG_C] = product[15];
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // register update
    // ------------------------------------------------------------
    // state and result registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            flags_reg <= FLAGS_RESET;
            low_reg <= ZERO_BYTE;
            high_reg <= ZERO_BYTE;
            valid_reg <= 1'b0;
            wide_reg <= 1'b0;
            pair_reg <= 1'b0;
            word_reg <= 17'h00000;
            wordSub_reg <= 1'b0;
            wordOrig_reg <= 16'h0000;
        end
        else
        begin
            state_reg <= state_next;
            flags_reg <= flags_next;
            low_reg <= low_next;
            high_reg <= high_next;
            valid_reg <= valid_next;
            wide_reg <= wide_next;
            pair_reg <= pair_next;
            word_reg <= word_next;
            wordSub_reg <= wordSub_next;
            wordOrig_reg <= wordOrig_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // busy covers the second cycle of word and product ops
    assign busy = (state_reg != ST_IDLE);

    // result handshake and data straight from registers
    assign resultValid = valid_reg;
    assign resultWide = wide_reg;
    assign productPair = pair_reg;
    assign resultLow = low_reg;
    assign resultHigh = high_reg;
    assign statusFlags = {1'b0, flags_reg};

endmodule

`default_nettype wire

// ==== src/alu_pkg.sv ====
package alu_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int OP_W = 5;

    // ------------------------------------------------------------
    // flag vector positions
    // ------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_W = 6;

    // ------------------------------------------------------------
    // constants and cycle counts
    // ------------------------------------------------------------
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam int SINGLE_CYCLES = 1;
    localparam int WORD_CYCLES = 2;
    localparam int PRODUCT_CYCLES = 2;

    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_ADD = 5'h00,
        OP_ADD_CARRY = 5'h01,
        OP_SUB = 5'h02,
        OP_SUB_IMM = 5'h03,
        OP_SUB_BORROW = 5'h04,
        OP_SUB_IMM_BORROW = 5'h05,
        OP_AND = 5'h06,
        OP_AND_IMM = 5'h07,
        OP_OR = 5'h08,
        OP_OR_IMM = 5'h09,
        OP_EXCL_OR = 5'h0a,
        OP_SET_BITS = 5'h0b,
        OP_CLEAR_BITS = 5'h0c,
        OP_TEST = 5'h0d,
        OP_INVERT = 5'h0e,
        OP_NEGATE = 5'h0f,
        OP_INCREMENT = 5'h10,
        OP_DECREMENT = 5'h11,
        OP_WORD_ADD = 5'h12,
        OP_WORD_SUB = 5'h13,
        OP_PROD_UU = 5'h14,
        OP_PROD_SS = 5'h15,
        OP_PROD_SU = 5'h16
    } alu_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WORD = 2'b01,
        ST_PROD = 2'b10
    } alu_state_t;

endpackage

// ==== src/byte_logic_unit.sv ====
`timescale 1ns/100ps
`default_nettype none

// single-cycle byte arithmetic and logic, combinational
module byte_logic_unit
    import alu_pkg::*;
(
    input wire alu_pkg::alu_op_t op,
    input wire logic [7:0] destVal,
    input wire logic [7:0] srcVal,
    input wire logic carryIn,
    output logic [7:0] result,
    output logic [5:0] flagsOut,
    output logic [5:0] flagsTouched
);

    logic [8:0] sum;
    logic [4:0] half;
    logic [7:0] opB;
    logic cin;
    logic isSub;
    logic isArith;

    // --------------------------------------------------------
    // operand select
    // --------------------------------------------------------
    always_comb
    begin
        opB = srcVal;
        cin = 1'b0;
        isSub = 1'b0;
        isArith = 1'b1;
        case (op)
            OP_ADD: cin = 1'b0;
            OP_ADD_CARRY: cin = carryIn;
            OP_SUB, OP_SUB_IMM: isSub = 1'b1;
            OP_SUB_BORROW, OP_SUB_IMM_BORROW:
            begin
                isSub = 1'b1;
                cin = carryIn;
            end
            OP_NEGATE:
            begin
                opB = destVal; // zero minus destination
                isSub = 1'b1;
            end
            OP_INCREMENT: opB = ONE_BYTE;
            OP_DECREMENT:
            begin
                opB = ONE_BYTE;
                isSub = 1'b1;
            end
            default: isArith = 1'b0;
        endcase
    end

    // --------------------------------------------------------
    // adder, subtraction borrow via a - b - c
    // --------------------------------------------------------
    always_comb
    begin
        logic [7:0] a;
        a = (op == OP_NEGATE) ? ZERO_BYTE : destVal;
        if (isSub)
        begin
            sum = {1'b0, a} - {1'b0, opB} - {8'h00, cin};
            half = {1'b0, a[3:0]} - {1'b0, opB[3:0]} - {4'h0, cin};
        end
        else
        begin
            sum = {1'b0, a} + {1'b0, opB} + {8'h00, cin};
            half = {1'b0, a[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
        end
    end

    // --------------------------------------------------------
    // result and flags
    // --------------------------------------------------------
    always_comb
    begin
        result = sum[7:0];
        flagsOut = FLAGS_RESET;
        flagsTouched = 6'h00;
        case (op)
            OP_AND, OP_AND_IMM, OP_TEST: result = destVal & srcVal;
            OP_OR, OP_OR_IMM, OP_SET_BITS: result = destVal | srcVal;
            OP_EXCL_OR: result = destVal ^ srcVal;
            OP_CLEAR_BITS: result = destVal & (ALL_ONES - srcVal);
            OP_INVERT: result = ALL_ONES - destVal;
            default: result = sum[7:0];
        endcase
        flagsOut[FLAG_Z] = (result == ZERO_BYTE);
        flagsOut[FLAG_N] = result[7];
        flagsTouched[FLAG_Z] = 1'b1;
        flagsTouched[FLAG_N] = 1'b1;
        flagsTouched[FLAG_V] = 1'b1;
        flagsTouched[FLAG_S] = 1'b1; // keeps sign consistent with n and v
        if (isArith)
        begin
            // signed overflow from operand and result signs
            if (op == OP_NEGATE)
                flagsOut[FLAG_V] = (result == 8'h80);
            else if (isSub)
                flagsOut[FLAG_V] = (destVal[7] ^ opB[7]) & (destVal[7] ^ result[7]);
            else
                flagsOut[FLAG_V] = ~(destVal[7] ^ opB[7]) & (destVal[7] ^ result[7]);
            if (op != OP_INCREMENT && op != OP_DECREMENT)
            begin
                flagsOut[FLAG_C] = sum[8];
                flagsOut[FLAG_H] = half[4];
                flagsTouched[FLAG_C] = 1'b1;
                flagsTouched[FLAG_H] = 1'b1;
            end
        end
        else if (op == OP_INVERT)
        begin
            flagsOut[FLAG_C] = 1'b1;
            flagsTouched[FLAG_C] = 1'b1;
        end
        flagsOut[FLAG_S] = flagsOut[FLAG_N] ^ flagsOut[FLAG_V];
    end

endmodule

`default_nettype wire

// ==== src/product_unit.sv ====
`timescale 1ns/100ps
`default_nettype none

// 8x8 multiplier with registered product, signedness per operand
module product_unit
    import alu_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    input wire logic aSigned,
    input wire logic bSigned,
    input wire logic [7:0] aVal,
    input wire logic [7:0] bVal,
    output logic [15:0] product
);

    logic [15:0] product_reg;
    logic [15:0] product_next;

    // --------------------------------------------------------
    // extend each operand and multiply
    // --------------------------------------------------------
    always_comb
    begin
        logic signed [8:0] ea;
        logic signed [8:0] eb;
        logic signed [17:0] full;
        ea = {aSigned & aVal[7], aVal};
        eb = {bSigned & bVal[7], bVal};
        full = ea * eb;
        product_next = start ? full[15:0] : product_reg;
    end

    // product register
    always_ff @(posedge mclk)
    begin
        if (rst)
            product_reg <= 16'h0000;
        else
            product_reg <= product_next;
    end

    assign product = product_reg;

endmodule

`default_nettype wire

// ==== verif/alu_properties.sv ====
`timescale 1ns/100ps
`default_nettype none

module alu_properties
    import alu_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic opValid,
    input wire alu_pkg::alu_op_t opCode,
    input wire logic [7:0] destVal,
    input wire logic [7:0] srcVal,
    input wire logic busy,
    input wire logic resultValid,
    input wire logic resultWide,
    input wire logic productPair,
    input wire logic [7:0] resultLow,
    input wire logic [7:0] resultHigh,
    input wire logic [6:0] statusFlags
);
    import alu_pkg::*;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    logic take;
    logic isWord;
    logic isProd;
    logic isLogic;

    // classes of the taken request
    assign take = opValid && !busy;
    assign isWord = opCode == OP_WORD_ADD || opCode == OP_WORD_SUB;
    assign isProd = opCode inside {OP_PROD_UU, OP_PROD_SS, OP_PROD_SU};
    assign isLogic = opCode inside {[OP_AND:OP_TEST]};

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // operation timing, results and flags
    // ------------------------------------------------------------
    sequence holdBusy;
        busy && !resultValid;
    endsequence

    sequence wideDone;
        resultValid && resultWide;
    endsequence

    byte_timing_a: assert property (take && !isWord && !isProd |=> resultValid && !resultWide)
        else $error("byte result not one cycle after request");
    word_timing_a: assert property (take && isWord |=>
        holdBusy ##1 (wideDone and (!productPair)))
        else $error("word result not two cycles after request");
    prod_timing_a: assert property (take && isProd |=>
        holdBusy ##1 (wideDone and productPair))
        else $error("product not two cycles after request");
    prod_flags_a: assert property (resultValid && productPair |->
        statusFlags[FLAG_C] == resultHigh[7] && statusFlags[FLAG_Z] == ({resultHigh, resultLow} == 16'h0000))
        else $error("product flags wrong");
    logic_flags_a: assert property (take && isLogic |=> !statusFlags[FLAG_V] &&
        statusFlags[FLAG_N] == resultLow[7] && statusFlags[FLAG_Z] == (resultLow == 8'h00))
        else $error("logic flags wrong");
    step_carry_a: assert property (take && (opCode == OP_INCREMENT || opCode == OP_DECREMENT)
        |=> $stable(statusFlags[FLAG_C]))
        else $error("carry changed by increment or decrement");
    sub_value_a: assert property (take && opCode == OP_SUB |=> resultLow == 8'($past(destVal) - $past(srcVal))
        && statusFlags[FLAG_C] == ($past(destVal) < $past(srcVal)))
        else $error("subtract result or borrow wrong");
    invert_value_a: assert property (take && opCode == OP_INVERT
        |=> statusFlags[FLAG_C] && resultLow == ~$past(destVal))
        else $error("invert result wrong");
    idle_quiet_a: assert property (!opValid && !busy |=> !resultValid)
        else $error("result without request");
endmodule

bind eight_bit_arith_logic_unit alu_properties i_alu_properties (
    .mclk(mclk),
    .rst(rst),
    .opValid(opValid),
    .opCode(opCode),
    .destVal(destVal),
    .srcVal(srcVal),
    .busy(busy),
    .resultValid(resultValid),
    .resultWide(resultWide),
    .productPair(productPair),
    .resultLow(resultLow),
    .resultHigh(resultHigh),
    .statusFlags(statusFlags)
);

`default_nettype wire

// ==== verif/reg_pair_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// register pair of the file with write-back bypass toward the datapath
module reg_pair_model (
    input wire logic mclk,
    input wire logic loadEn,
    input wire logic [15:0] loadWord,
    input wire logic resultValid,
    input wire logic resultWide,
    input wire logic productPair,
    input wire logic [7:0] resultLow,
    input wire logic [7:0] resultHigh,
    output logic [7:0] destVal,
    output logic [7:0] destHighVal
);
    logic [7:0] lowReg;
    logic [7:0] highReg;
    logic backLow;
    logic backHigh;

    // product goes to the fixed pair, not to the working pair
    assign backLow = resultValid && !productPair;
    assign backHigh = backLow && resultWide;
    assign destVal = backLow ? resultLow : lowReg;
    assign destHighVal = backHigh ? resultHigh : highReg;

    // preload wins over write-back
    always_ff @(posedge mclk)
    begin
        if (loadEn)
        begin
            lowReg <= loadWord[7:0];
            highReg <= loadWord[15:8];
        end
        else
        begin
            if (backLow)
                lowReg <= resultLow;
            if (backHigh)
                highReg <= resultHigh;
        end
    end
endmodule

`default_nettype wire

// ==== verif/eight_bit_arith_logic_unit_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module eight_bit_arith_logic_unit_tb_top;
    import alu_pkg::*;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic opValid = 1'b0;
    alu_op_t opCode = OP_ADD;
    logic [7:0] srcVal = 8'h00;
    logic [7:0] immVal = 8'h00;
    logic [5:0] immWord = 6'h00;
    logic loadEn = 1'b0;
    logic [15:0] loadWord = 16'h0000;
    logic [7:0] destVal;
    logic [7:0] destHighVal;
    logic busy;
    logic resultValid;
    logic resultWide;
    logic productPair;
    logic [7:0] resultLow;
    logic [7:0] resultHigh;
    logic [6:0] statusFlags;
    int nMismatch = 0;
    int samplesChecked = 0;

    always #10 mclk = ~mclk;

    eight_bit_arith_logic_unit i_eight_bit_arith_logic_unit (
        .mclk(mclk), .rst(rst), .opValid(opValid), .opCode(opCode),
        .destVal(destVal), .srcVal(srcVal), .immVal(immVal),
        .destHighVal(destHighVal), .immWord(immWord), .busy(busy),
        .resultValid(resultValid), .resultWide(resultWide), .productPair(productPair),
        .resultLow(resultLow), .resultHigh(resultHigh), .statusFlags(statusFlags)
    );

    reg_pair_model i_reg_pair_model (
        .mclk(mclk), .loadEn(loadEn), .loadWord(loadWord), .resultValid(resultValid),
        .resultWide(resultWide), .productPair(productPair), .resultLow(resultLow),
        .resultHigh(resultHigh), .destVal(destVal), .destHighVal(destHighVal)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic endSim;
        $display("checks=%0d mismatches=%0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // preset the working pair; also ends any held request
    task automatic preload(input logic [15:0] w);
        opValid = 1'b0;
        loadEn = 1'b1;
        loadWord = w;
        @(posedge mclk);
        #1;
        loadEn = 1'b0;
    endtask

    // byte ops leave the strobe up so the next one follows back to back
    task automatic step(input alu_op_t op, input logic [7:0] src, input logic [7:0] imm,
                        input logic [5:0] w, input logic [15:0] expRes, input logic [6:0] expFlags);
        int i;
        opCode = op;
        srcVal = src;
        immVal = imm;
        immWord = w;
        opValid = 1'b1;
        @(posedge mclk);
        #1;
        if (resultValid !== 1'b1)
            opValid = 1'b0;
        for (i = 0; i < 4 && resultValid !== 1'b1; i++)
        begin
            @(posedge mclk);
            #1;
        end
        if (i == 4)
        begin
            nMismatch++;
            endSim();
        end
        check({resultWide ? resultHigh : 8'h00, resultLow}, expRes);
        check({9'h000, statusFlags}, {9'h000, expFlags});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic arithChain;
        preload(16'h0010);
        step(OP_SUB, 8'h21, 8'h00, 6'h00, 16'h00ef, 7'h35);
        step(OP_SUB_BORROW, 8'h0e, 8'h00, 6'h00, 16'h00e0, 7'h14);
        step(OP_SUB_IMM_BORROW, 8'h00, 8'he0, 6'h00, 16'h0000, 7'h02);
        step(OP_SUB_IMM, 8'h00, 8'h01, 6'h00, 16'h00ff, 7'h35);
        step(OP_ADD_CARRY, 8'h80, 8'h00, 6'h00, 16'h0080, 7'h35);
        step(OP_SUB, 8'h01, 8'h00, 6'h00, 16'h007f, 7'h38);
        step(OP_ADD, 8'h01, 8'h00, 6'h00, 16'h0080, 7'h2c);
        preload(16'h007f);
        $display("arith chain done");
    endtask

    task automatic logicChain;
        step(OP_AND, 8'h0f, 8'h00, 6'h00, 16'h000f, 7'h20);
        step(OP_AND_IMM, 8'h00, 8'hf0, 6'h00, 16'h0000, 7'h22);
        step(OP_OR, 8'h81, 8'h00, 6'h00, 16'h0081, 7'h34);
        step(OP_OR_IMM, 8'h00, 8'h02, 6'h00, 16'h0083, 7'h34);
        step(OP_EXCL_OR, 8'h83, 8'h00, 6'h00, 16'h0000, 7'h22);
        step(OP_SET_BITS, 8'h00, 8'h90, 6'h00, 16'h0090, 7'h34);
        step(OP_CLEAR_BITS, 8'h00, 8'h80, 6'h00, 16'h0010, 7'h20);
        step(OP_TEST, 8'h00, 8'h00, 6'h00, 16'h0010, 7'h20);
        step(OP_INCREMENT, 8'h00, 8'h00, 6'h00, 16'h0011, 7'h20);
        step(OP_DECREMENT, 8'h00, 8'h00, 6'h00, 16'h0010, 7'h20);
        step(OP_NEGATE, 8'h00, 8'h00, 6'h00, 16'h00f0, 7'h15);
        step(OP_INVERT, 8'h00, 8'h00, 6'h00, 16'h000f, 7'h01);
        $display("logic chain done");
    endtask

    task automatic wordOps;
        preload(16'hffc0);
        step(OP_WORD_ADD, 8'h00, 8'h00, 6'h3f, 16'hffff, 7'h14);
        step(OP_WORD_ADD, 8'h00, 8'h00, 6'h01, 16'h0000, 7'h03);
        step(OP_WORD_SUB, 8'h00, 8'h00, 6'h01, 16'hffff, 7'h15);
        preload(16'h7ff0);
        step(OP_WORD_ADD, 8'h00, 8'h00, 6'h10, 16'h8000, 7'h0c);
        step(OP_WORD_SUB, 8'h00, 8'h00, 6'h01, 16'h7fff, 7'h18);
        $display("word ops done");
    endtask

    task automatic productOps;
        preload(16'h00ff);
        step(OP_PROD_UU, 8'hff, 8'h00, 6'h00, 16'hfe01, 7'h19);
        step(OP_PROD_SS, 8'hff, 8'h00, 6'h00, 16'h0001, 7'h18);
        step(OP_PROD_SU, 8'h02, 8'h00, 6'h00, 16'hfffe, 7'h19);
        step(OP_PROD_UU, 8'h00, 8'h00, 6'h00, 16'h0000, 7'h1a);
        $display("product ops done");
    endtask

    task automatic resetMid;
        opValid = 1'b0;
        rst = 1'b1;
        repeat (2)
        begin
            @(posedge mclk);
            #1;
        end
        check({busy, resultValid, statusFlags[5:0], resultLow}, 16'h0000);
        rst = 1'b0;
        // the working pair is not cleared by the datapath reset
        preload(16'h0000);
        step(OP_SUB, 8'h01, 8'h00, 6'h00, 16'h00ff, 7'h35);
        preload(16'h0000);
        $display("mid-run reset done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge mclk);
        #1;
        rst = 1'b0;
        check({9'h000, statusFlags}, 16'h0000);
        arithChain();
        logicChain();
        wordOps();
        productOps();
        resetMid();
        endSim();
    end
endmodule

`default_nettype wire
